// >>> hw/cfr_regs.sv
// Configuration, sub-address and setup register bank with an APB slave port.
//
// Functional notes
// - Configuration loads 0001 1000 on hardware reset; software reset leaves it.
// - Low three sub-address bits choose the register seen at location 7h.
// - Two low sub-address bits are one copy shared with configuration.
// - Top sub-address bit set routes the shared location to setup 2.
// - Every configuration write with the low byte strobe set clears the top sub-address bit.
// - Setup 1 divides the data rate by 1 to 128 in powers of two and halves arbitration separately.
// - Setup 1 holds receive-all and the first pulse output driver type.
// - Setup 1 clears to zero on hardware reset only.
// - Two setup 2 bits select the clock made from the 20 MHz crystal.
// - A setup 2 bit enables the fast read cycle for fast hosts.
// - Enhanced-timing bit low keeps old timing, high applies new timing.
// - No-sync bit low writes init only on idle line, high always.
// - Recon bits give 6.72 S, 1.68 S, 840 mS or 420 mS.
// - Recon periods hold at 312.5 Kbps and scale with the data rate.
`timescale 1ns/1ps
`include "cfr_map.svh"

module cfr_regs
  import cfr_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB request
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  // APB answer
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Software reset from the command logic
  input wire logic soft_reset,
  // Configuration and sub-address state
  output logic [7:0] mode_configuration,
  output logic [2:0] location_select_field,
  // Setup 1 controls
  output logic arbitration_half_speed,
  output logic [2:0] data_rate_divide_log2,
  output logic receive_all,
  output logic four_nak_limit,
  output logic first_pulse_output_mode,
  // Setup 2 controls
  output logic [1:0] crystal_clock_select,
  output logic fast_read_timing_enable,
  output logic enhanced_timing_enable,
  output logic init_without_idle_line,
  output logic [1:0] recon_period_sel,
  // Recon timeout in microseconds at the selected data rate
  output logic [31:0] recon_timeout_us
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  initial begin
    if (ADDR_W < 5) begin
      $error("Address width too narrow for the register map.");
    end
    if (ADDR_W > 12) begin
      $error("Address width wider than the decoded address.");
    end
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] config_r;
  logic [5:0] config_hi_r;
  logic [2:0] subaddr_r;
  logic [7:0] setup1_r;
  logic [7:0] clock_timing_recon_setup_r;
  cfr_bus_t bus_r;
  logic pready_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic [31:0] recon_r;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic [11:0] addr_w;
  logic hit_config;
  logic hit_subaddr;
  logic hit_shared;
  logic mapped;
  logic setup_phase;
  logic wr_commit;
  logic lane0;
  cfr_loc_t loc;

  assign addr_w = 12'(paddr);
  assign hit_config = (addr_w == `CFR_ADDR_CONFIG);
  assign hit_subaddr = (addr_w == `CFR_ADDR_SUBADDR);
  assign hit_shared = (addr_w == `CFR_ADDR_SHARED);
  assign mapped = hit_config | hit_subaddr | hit_shared;
  assign setup_phase = psel & ~penable;
  assign wr_commit = psel & penable & pready & pwrite & mapped;
  assign lane0 = pstrb[0];

  // Shared location target from the sub-address bits.
  always_comb begin
    if (subaddr_r[`CFR_SUB_TOP_BIT]) begin
      loc = CFR_LOC_CLOCK_TIMING_RECON_SETUP;
    end else if (subaddr_r == `CFR_SUB_SETUP1) begin
      loc = CFR_LOC_SETUP1;
    end else begin
      loc = CFR_LOC_NONE;
    end
  end

  // ----------------------------------------------------------------
  // Write enables
  // ----------------------------------------------------------------
  // Every write is qualified by the low byte strobe, since each register is one byte.
  logic we_config;
  logic we_subaddr;
  logic we_setup1;
  logic we_clock_timing_recon_setup;

  assign we_config = wr_commit & hit_config & lane0;
  assign we_subaddr = wr_commit & hit_subaddr & lane0;
  assign we_setup1 = wr_commit & hit_shared & lane0 & (loc == CFR_LOC_SETUP1);
  assign we_clock_timing_recon_setup = wr_commit & hit_shared & lane0 & (loc == CFR_LOC_CLOCK_TIMING_RECON_SETUP);

  // ----------------------------------------------------------------
  // Bus phase: one wait-free answer per transfer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_r <= CFR_BUS_IDLE;
    end else begin
      unique case (bus_r)
        CFR_BUS_IDLE: begin
          if (setup_phase) begin
            bus_r <= CFR_BUS_ANSWER;
          end
        end
        CFR_BUS_ANSWER: begin
          bus_r <= CFR_BUS_IDLE;
        end
      endcase
    end
  end

  // The answer is registered so that pready leaves on a flip-flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= (bus_r == CFR_BUS_IDLE) && setup_phase;
    end
  end

  assign pready = pready_r;

  // ----------------------------------------------------------------
  // Read data and error, captured in the setup phase
  // ----------------------------------------------------------------
  function automatic logic [7:0] read_mux(
    input logic c, input logic s, input logic h, input cfr_loc_t l,
    input logic [7:0] cfg, input logic [2:0] sub,
    input logic [7:0] s1, input logic [7:0] s2);
    logic [7:0] v;
    v = 8'h00;
    if (c) begin
      v = cfg;
    end else if (s) begin
      v = {5'h00, sub};
    end else if (h) begin
      unique case (l)
        CFR_LOC_SETUP1: v = s1;
        CFR_LOC_CLOCK_TIMING_RECON_SETUP: v = s2;
        CFR_LOC_NONE: v = 8'h00;
      endcase
    end
    return v;
  endfunction : read_mux

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup_phase && !pwrite) begin
      prdata_r <= {24'h00_0000, read_mux(hit_config, hit_subaddr, hit_shared, loc,
                                          config_r, subaddr_r, setup1_r, clock_timing_recon_setup_r)};
    end else if (pready) begin
      prdata_r <= 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_r <= 1'b0;
    end else if (setup_phase) begin
      pslverr_r <= ~mapped;
    end else begin
      pslverr_r <= 1'b0;
    end
  end

  assign prdata = prdata_r;
  assign pslverr = pslverr_r;

  // ----------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------
  // Software reset does not touch any register of this bank.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_hi_r <= 6'(`CFR_CONFIG_RST >> 2);
    end else if (we_config) begin
      config_hi_r <= pwdata[7:2];
    end
  end

  // Low two bits are a view of the shared sub-address copy.
  always_comb begin
    config_r = {config_hi_r, subaddr_r[1:0]};
  end

  // ----------------------------------------------------------------
  // Sub-address register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      subaddr_r <= `CFR_SUBADDR_RST;
    end else if (we_config) begin
      subaddr_r <= {1'b0, pwdata[1:0]};
    end else if (we_subaddr) begin
      subaddr_r <= pwdata[2:0];
    end
  end

  // ----------------------------------------------------------------
  // Setup 1 register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup1_r <= `CFR_SETUP1_RST;
    end else if (we_setup1) begin
      setup1_r <= pwdata[7:0] & `CFR_S1_WMASK;
    end
  end

  // ----------------------------------------------------------------
  // Setup 2 register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_timing_recon_setup_r <= `CFR_CLOCK_TIMING_RECON_SETUP_RST;
    end else if (we_clock_timing_recon_setup) begin
      clock_timing_recon_setup_r <= pwdata[7:0] & `CFR_S2_WMASK;
    end
  end

  // ----------------------------------------------------------------
  // Recon timeout scaled to the data rate
  // ----------------------------------------------------------------
  logic [31:0] recon_base;
  logic [2:0] rate_div;

  assign rate_div = setup1_r[`CFR_S1_RATE_MSB:`CFR_S1_RATE_LSB];

  always_comb begin
    unique case (clock_timing_recon_setup_r[`CFR_S2_RECON_MSB:`CFR_S2_RECON_LSB])
      2'b00: recon_base = `CFR_RECON_00_US;
      2'b01: recon_base = `CFR_RECON_01_US;
      2'b10: recon_base = `CFR_RECON_10_US;
      2'b11: recon_base = `CFR_RECON_11_US;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      recon_r <= `CFR_RECON_00_US;
    end else begin
      // The longest period shifted by seven still fits in 32 bits.
      recon_r <= recon_base << rate_div;
    end
  end

  assign recon_timeout_us = recon_r;

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  logic [7:0] cfg_out_r;
  logic [2:0] sub_out_r;
  logic [7:0] s1_out_r;
  logic [7:0] s2_out_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_out_r <= `CFR_CONFIG_RST;
      sub_out_r <= `CFR_SUBADDR_RST;
    end else begin
      cfg_out_r <= config_r;
      sub_out_r <= subaddr_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_out_r <= `CFR_SETUP1_RST;
      s2_out_r <= `CFR_CLOCK_TIMING_RECON_SETUP_RST;
    end else begin
      s1_out_r <= setup1_r;
      s2_out_r <= clock_timing_recon_setup_r;
    end
  end

  assign mode_configuration = cfg_out_r;
  assign location_select_field = sub_out_r;
  assign arbitration_half_speed = s1_out_r[`CFR_S1_ARB_SLOW];
  assign data_rate_divide_log2 = s1_out_r[`CFR_S1_RATE_MSB:`CFR_S1_RATE_LSB];
  assign receive_all = s1_out_r[`CFR_S1_RCV_ALL];
  assign four_nak_limit = s1_out_r[`CFR_S1_FOUR_NAKS];
  assign first_pulse_output_mode = s1_out_r[`CFR_S1_PULSE_MODE];
  assign crystal_clock_select = s2_out_r[`CFR_S2_CKUP_MSB:`CFR_S2_CKUP_LSB];
  assign fast_read_timing_enable = s2_out_r[`CFR_S2_FAST_READ];
  assign enhanced_timing_enable = s2_out_r[`CFR_S2_ENH];
  assign init_without_idle_line = s2_out_r[`CFR_S2_INIT_WITHOUT_IDLE_LINE];
  assign recon_period_sel = s2_out_r[`CFR_S2_RECON_MSB:`CFR_S2_RECON_LSB];

  // Software reset is accepted and deliberately left without effect here.
  logic soft_reset_unused;
  assign soft_reset_unused = soft_reset;

  // Upper data bytes and upper strobes have no register behind them.
  logic unused_bits;
  assign unused_bits = ^{pwdata[31:8], pstrb[3:1]};

endmodule : cfr_regs

// >>> shared/cfr_map.svh
// Register offsets, field positions, reset values and timing figures of the setup register bank.
`ifndef CFR_MAP_SVH
`define CFR_MAP_SVH

// ----------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------
`define CFR_IDX_SUBADDR 3
`define CFR_IDX_CONFIG 6
`define CFR_IDX_SHARED 7
`define CFR_ADDR_SUBADDR 12'h00c
`define CFR_ADDR_CONFIG 12'h018
`define CFR_ADDR_SHARED 12'h01c

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CFR_CONFIG_RST 8'h18
`define CFR_SETUP1_RST 8'h00
`define CFR_CLOCK_TIMING_RECON_SETUP_RST 8'h00
`define CFR_SUBADDR_RST 3'h0

// ----------------------------------------------------------------
// Sub-address codes
// ----------------------------------------------------------------
`define CFR_SUB_SETUP1 3'h2
`define CFR_SUB_TOP_BIT 2

// ----------------------------------------------------------------
// Setup 1 fields
// ----------------------------------------------------------------
`define CFR_S1_ARB_SLOW 0
`define CFR_S1_RATE_LSB 1
`define CFR_S1_RATE_MSB 3
`define CFR_S1_RCV_ALL 4
`define CFR_S1_FOUR_NAKS 6
`define CFR_S1_PULSE_MODE 7
`define CFR_S1_WMASK 8'hdf

// ----------------------------------------------------------------
// Setup 2 fields
// ----------------------------------------------------------------
`define CFR_S2_RECON_LSB 0
`define CFR_S2_RECON_MSB 1
`define CFR_S2_INIT_WITHOUT_IDLE_LINE 2
`define CFR_S2_ENH 3
`define CFR_S2_CKUP_LSB 5
`define CFR_S2_CKUP_MSB 6
`define CFR_S2_FAST_READ 7
`define CFR_S2_WMASK 8'hef

// ----------------------------------------------------------------
// Timing: recon periods in microseconds at the full data rate
// ----------------------------------------------------------------
`define CFR_CLK_PERIOD_NS 40
`define CFR_FULL_RATE_BPS 312500
`define CFR_RECON_00_US 32'd6720000
`define CFR_RECON_01_US 32'd1680000
`define CFR_RECON_10_US 32'd840000
`define CFR_RECON_11_US 32'd420000

`endif

// >>> shared/cfr_pkg.sv
// Types shared by the setup register bank.
package cfr_pkg;

  // Target reached through the shared location.
  typedef enum logic [1:0] {
    CFR_LOC_NONE,
    CFR_LOC_SETUP1,
    CFR_LOC_CLOCK_TIMING_RECON_SETUP
  } cfr_loc_t;

  // Slave bus phase.
  typedef enum logic {
    CFR_BUS_IDLE,
    CFR_BUS_ANSWER
  } cfr_bus_t;

endpackage : cfr_pkg

// >>> bench/cfr_regs_asserts.sv
// Port checker of the setup register bank.
`timescale 1ns/1ps
`include "cfr_map.svh"
module cfr_regs_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Register state
  input wire logic [7:0] mode_configuration,
  input wire logic [2:0] location_select_field,
  input wire logic [2:0] data_rate_divide_log2,
  input wire logic [1:0] recon_period_sel,
  input wire logic [31:0] recon_timeout_us
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic cw;
  assign cw = psel && penable && pready && pwrite && pstrb[0] && paddr == `CFR_ADDR_CONFIG;
  function automatic logic [31:0] tab(input logic [1:0] s);
    return s == 2'd0 ? `CFR_RECON_00_US : s == 2'd1 ? `CFR_RECON_01_US :
      s == 2'd2 ? `CFR_RECON_10_US : `CFR_RECON_11_US;
  endfunction : tab
  a_ready_follows: assert property (psel && !penable |=> pready)
    else $error("pready missing");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready held");
  a_top_cleared: assert property (cw |-> ##2 !location_select_field[2])
    else $error("top select bit kept");
  a_low_shared: assert property (cw |-> ##2 location_select_field[1:0] == $past(pwdata[1:0], 2))
    else $error("select bits differ");
  a_cfg_stored: assert property (cw |-> ##2 mode_configuration[7:2] == $past(pwdata[7:2], 2))
    else $error("config not stored");
  a_reset_value: assert property ($rose(presetn) |-> mode_configuration == `CFR_CONFIG_RST)
    else $error("config reset value");
  a_read_byte: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read upper bits");
  a_unmapped: assert property (psel && !penable && !(paddr inside {`CFR_ADDR_SUBADDR,
    `CFR_ADDR_CONFIG, `CFR_ADDR_SHARED}) |=> pslverr && prdata == 32'h0)
    else $error("unmapped access");
  a_recon_table: assert property (recon_timeout_us ==
    tab(recon_period_sel) << data_rate_divide_log2)
    else $error("recon period");
endmodule : cfr_regs_chk

bind cfr_regs cfr_regs_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pstrb, .pready, .prdata, .pslverr, .mode_configuration, .location_select_field,
  .data_rate_divide_log2, .recon_period_sel, .recon_timeout_us);

// >>> bench/cfr_host.sv
// Host model that makes APB transfers.
`timescale 1ns/1ps
module cfr_host (
  // Clock
  input wire logic pclk,
  // Request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  // Answer
  input wire logic pready
);
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
  end
  // Flags to when pready never comes within 64 cycles; released address and data lines show inverted values.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic to);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    to = pready !== 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : cfr_host

// >>> bench/cfr_regs_tb.sv
// Self-checking testbench of the setup register bank.
`timescale 1ns/1ps
`include "cfr_map.svh"
module cfr_regs_tb;
  localparam logic [11:0] AC = `CFR_ADDR_CONFIG;
  localparam logic [11:0] AB = `CFR_ADDR_SUBADDR;
  localparam logic [11:0] AS = `CFR_ADDR_SHARED;
  logic pclk, presetn, soft_reset, psel, penable, pwrite, pready, pslverr, to;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, recon_timeout_us, seed, r;
  logic [3:0] pstrb;
  logic [7:0] mode_configuration, cfg, s1, s2;
  logic [2:0] location_select_field, data_rate_divide_log2, sub;
  logic [1:0] crystal_clock_select, recon_period_sel;
  logic arbitration_half_speed, receive_all, four_nak_limit, first_pulse_output_mode;
  logic fast_read_timing_enable, enhanced_timing_enable, init_without_idle_line;
  logic [32:0] q[$];
  int n_mismatch, samples_checked;
  cfr_host host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready);
  cfr_regs DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
    .prdata, .pslverr, .soft_reset, .mode_configuration, .location_select_field,
    .arbitration_half_speed, .data_rate_divide_log2, .receive_all, .four_nak_limit,
    .first_pulse_output_mode, .crystal_clock_select, .fast_read_timing_enable,
    .enhanced_timing_enable, .init_without_idle_line, .recon_period_sel, .recon_timeout_us);
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [31:0] recon_exp(input logic [1:0] s);
    return s == 2'd0 ? `CFR_RECON_00_US : s == 2'd1 ? `CFR_RECON_01_US :
      s == 2'd2 ? `CFR_RECON_10_US : `CFR_RECON_11_US;
  endfunction : recon_exp
  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] st);
    host.xfer(1'b1, a, {24'h0, d}, st, to);
    if (to) begin
      n_mismatch++;
      complete_run();
    end
    if (st[0] && a == AC) {cfg, sub} = {d, 1'b0, d[1:0]};
    if (st[0] && a == AB) sub = d[2:0];
    if (st[0] && a == AS && sub[2]) s2 = d & `CFR_S2_WMASK;
    else if (st[0] && a == AS && sub == 3'h2) s1 = d & `CFR_S1_WMASK;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    logic [7:0] e;
    e = a == AC ? {cfg[7:2], sub[1:0]} : a == AB ? {5'h0, sub} : a != AS ? 8'h0 :
      sub[2] ? s2 : sub == 3'h2 ? s1 : 8'h0;
    q.push_back({!(a inside {AB, AC, AS}), 24'h0, e});
    host.xfer(1'b0, a, 32'h0, 4'hf, to);
    if (to) begin
      n_mismatch++;
      complete_run();
    end
  endtask : rd
  task automatic fields();
    repeat (2) @(posedge pclk);
    check("setup1", 33'({first_pulse_output_mode, four_nak_limit, receive_all,
      data_rate_divide_log2, arbitration_half_speed}), 33'({s1[7:6], s1[4:0]}));
    check("clock_timing_recon_setup", 33'({fast_read_timing_enable, crystal_clock_select, enhanced_timing_enable,
      init_without_idle_line, recon_period_sel}), 33'({s2[7:5], s2[3:0]}));
    check("select", 33'(location_select_field), 33'(sub));
    check("config", 33'(mode_configuration[7:2]), 33'(cfg[7:2]));
    check("recon", 33'(recon_timeout_us), 33'(recon_exp(s2[1:0]) << s1[3:1]));
  endtask : fields
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    {cfg, s1, s2, sub} = {8'h18, 19'h0};
  endtask : do_reset
  always @(posedge pclk) begin
    if (pready === 1'b1 && pwrite === 1'b0) begin
      if (q.size() == 0) check("extra read", 33'h0, 33'h1);
      else check("read", {pslverr, prdata}, q.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    complete_run();
  end
  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    {presetn, soft_reset, n_mismatch, samples_checked} = '0;
    seed = 32'h716f4c10;
    do_reset();
    rd(AC);
    wr(AB, 8'h02, 4'hf);
    rd(AS);
    for (int i = 0; i < 8; i++) begin
      soft_reset <= i[0];
      r = rnd();
      wr(AB, {5'h0, i[2:0]}, 4'hf);
      wr(AS, {r[7:2], i[1:0]}, 4'hf);
      rd(AS);
      fields();
      wr(AC, {r[15:10], i[0] ? r[9:8] : 2'b10}, 4'hf);
      wr(AS, r[23:16], 4'hf);
      rd(AS);
      rd(AC);
      rd(AB);
      fields();
    end
    wr(AC, 8'hff, 4'h0);
    rd(AC);
    wr(12'h020, 8'hff, 4'hf);
    rd(12'h020);
    do_reset();
    rd(AC);
    fields();
    @(posedge pclk);
    check("pending", 33'(q.size()), 33'h0);
    complete_run();
  end
endmodule : cfr_regs_tb
